// *** verilog/tfs_consts.vh ***
// Constants for the traverse frequency sequencer: register offsets, reset
// values, limits and timing figures. Definitions only; include by bare name.
`ifndef TFS_CONSTS_VH
`define TFS_CONSTS_VH

// Register offsets (word index on the plain register port)
`define TFS_A_OPSEL     8'h00
`define TFS_A_FIRST     8'h01
`define TFS_A_SECOND    8'h02
`define TFS_A_DELTA     8'h03
`define TFS_A_ACC1      8'h04
`define TFS_A_ACC2      8'h05
`define TFS_A_DEC1      8'h06
`define TFS_A_DEC2      8'h07
`define TFS_A_GAIN      8'h08
`define TFS_A_ALTGAIN   8'h09
`define TFS_A_INSEL     8'h0a
`define TFS_A_OFFSET    8'h0b
`define TFS_A_SRCSEL    8'h0c
`define TFS_A_LOOPMODE  8'h0d
`define TFS_A_BIAS      8'h0e
`define TFS_A_JOGFREQ   8'h0f
`define TFS_A_GAINSEL   8'h10
`define TFS_A_TERM0     8'h18
`define TFS_A_STATUS    8'h20
`define TFS_A_OUTFREQ   8'h21
`define TFS_A_WORKA     8'h22
`define TFS_A_WORKB     8'h23
`define TFS_A_MOD       8'h24

// Reset values
`define TFS_R_OPSEL     3'h0
`define TFS_R_FREQ      16'h0000
`define TFS_R_TIME      16'h0064
`define TFS_R_SEL       3'h0
`define TFS_R_BYTE      8'h00

// Limits and codes (frequency in 0.1 Hz, time in 0.1 s, rate in percent)
`define TFS_OP_TRAVERSE 3'h2
`define TFS_FREQ_MAX    16'h1770
`define TFS_TIME_MAX    16'hfde8
`define TFS_OFFSET_MAX  8'h32
`define TFS_INSEL_MAX   3'h5
`define TFS_PID_MODE    8'h03
`define TFS_HOLD_FUNC   8'h26
`define TFS_CUR_ZERO    12'h333
`define TFS_ADC_FULL    12'hfff
`define TFS_PCT_SCALE   20'h00064
`define TFS_MOD_RECIP   16'h28f6

// Timing: one time unit is 100 ms, the clock period 25 ns
`define TFS_TIME_UNIT_NS 100000000
`define TFS_CLK_NS      25

`endif

// *** verilog/tfs_sequencer.v ***
// Traverse frequency sequencer: ramp generator, traverse state machine,
// analog modulation and its register file behind a plain register port.
// Assumes 12-bit digitized analog inputs on ref_clk, and terminal pins that
// arrive asynchronously and are synchronised here.
//
// Summary of operation
// RULE1: Selector value 2 enters traverse mode.
// RULE2: Run swings target between both setpoints endlessly.
// RULE3: Reaching first setpoint targets first minus delta.
// RULE4: Reaching second setpoint targets second plus delta.
// RULE5: Endpoints touched momentarily, no dwell.
// RULE6: First ramp times for start and stop.
// RULE7: Second ramp times for all other legs.
// RULE8: First setpoint only from stored parameter.
// RULE9: Ramp-select pins ignored unless hold function.
// RULE10: Speed-select pins ignored in traverse mode.
// RULE11: Restarts ramp toward the first setpoint.
// RULE12: Nonzero input selector enables modulation source.
// RULE13: Selector codes pick input and range.
// RULE14: Full scale gives gain, up to 600 Hz.
// RULE15: Modulation added to working targets only.
// RULE16: Negative gain gives falling negative modulation.
// RULE17: Offset rate accepted from 0 to 50%.
// RULE18: Jog before traverse behaves as ordinary.
// RULE19: Offset sets zero point, span equals gain.
// RULE20: PID loop mode disables modulation.
// RULE21: Bias setting never touches modulation.
// RULE22: Modulation linear, recomputed continuously.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "tfs_consts.vh"

module tfs_sequencer #(
  parameter RAMP_CYC = `TFS_TIME_UNIT_NS / `TFS_CLK_NS,
  parameter TERMS = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire run_cmd,
  input wire jog_cmd,
  input wire restart_req,
  input wire ramp_select_input_a,
  input wire ramp_select_input_b,
  input wire speed_select_input_a,
  input wire speed_select_input_b,
  input wire [11:0] voltage_mod_input_a,
  input wire [11:0] voltage_mod_input_b,
  input wire [11:0] current_mod_input,
  output reg [15:0] out_freq,
  output reg [15:0] target_freq,
  output reg second_ramp_set,
  output wire traverse_active
);

  localparam S_IDLE = 3'h0;
  localparam S_START = 3'h1;
  localparam S_LEG_B = 3'h2;
  localparam S_OVER_B = 3'h3;
  localparam S_LEG_A = 3'h4;
  localparam S_OVER_A = 3'h5;
  localparam S_STOP = 3'h6;
  localparam S_PLAIN = 3'h7;
  localparam [39:0] RCYC = RAMP_CYC;

  //////////////////////////////////////////////////////////////////////////
  // Parameter registers

  reg [2:0] operation_function_selector;
  reg [15:0] first_speed_setpoint;
  reg [15:0] second_speed_setpoint;
  reg [15:0] traverse_step_delta;
  reg [15:0] first_accel_time;
  reg [15:0] second_accel_time;
  reg [15:0] first_decel_time;
  reg [15:0] second_decel_time;
  reg signed [15:0] modulation_gain_frequency;
  reg signed [15:0] alt_modulation_gain_frequency;
  reg [2:0] modulation_input_selector;
  reg [7:0] modulation_offset_rate;
  reg [7:0] first_speed_source_select;
  reg [7:0] control_loop_mode_select;
  reg [15:0] bias_frequency_setting;
  reg [15:0] jog_freq;
  reg gain_alt_sel;
  reg [7:0] term_func [0:TERMS-1];
  reg [2:0] state;
  reg [2:0] next_state;

  // Clamp helpers for written values
  function [15:0] clamp_u;
    input [15:0] v;
    input [15:0] lim;
    begin
      clamp_u = (v > lim) ? lim : v;
    end
  endfunction

  function [15:0] clamp_s;
    input [15:0] v;
    begin
      if ($signed(v) > $signed(`TFS_FREQ_MAX))
        clamp_s = `TFS_FREQ_MAX;
      else if ($signed(v) < -$signed(`TFS_FREQ_MAX))
        clamp_s = -`TFS_FREQ_MAX;
      else
        clamp_s = v;
    end
  endfunction

  // Register writes; out-of-range values saturate to the legal limits
  always @(posedge ref_clk) begin
    if (rst) begin
      operation_function_selector <= `TFS_R_OPSEL;
      first_speed_setpoint <= `TFS_R_FREQ;
      second_speed_setpoint <= `TFS_R_FREQ;
      traverse_step_delta <= `TFS_R_FREQ;
      first_accel_time <= `TFS_R_TIME;
      second_accel_time <= `TFS_R_TIME;
      first_decel_time <= `TFS_R_TIME;
      second_decel_time <= `TFS_R_TIME;
      modulation_gain_frequency <= `TFS_R_FREQ;
      alt_modulation_gain_frequency <= `TFS_R_FREQ;
      modulation_input_selector <= `TFS_R_SEL;
      modulation_offset_rate <= `TFS_R_BYTE;
      first_speed_source_select <= `TFS_R_BYTE;
      control_loop_mode_select <= `TFS_R_BYTE;
      bias_frequency_setting <= `TFS_R_FREQ;
      jog_freq <= `TFS_R_FREQ;
      gain_alt_sel <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `TFS_A_OPSEL: operation_function_selector <= reg_wdata[2:0];
        `TFS_A_FIRST: first_speed_setpoint <= clamp_u(reg_wdata, `TFS_FREQ_MAX);
        `TFS_A_SECOND: second_speed_setpoint <= clamp_u(reg_wdata, `TFS_FREQ_MAX);
        `TFS_A_DELTA: traverse_step_delta <= clamp_u(reg_wdata, `TFS_FREQ_MAX);
        `TFS_A_ACC1: first_accel_time <= clamp_u(reg_wdata, `TFS_TIME_MAX);
        `TFS_A_ACC2: second_accel_time <= clamp_u(reg_wdata, `TFS_TIME_MAX);
        `TFS_A_DEC1: first_decel_time <= clamp_u(reg_wdata, `TFS_TIME_MAX);
        `TFS_A_DEC2: second_decel_time <= clamp_u(reg_wdata, `TFS_TIME_MAX);
        // RULE14: signed gain limit
        `TFS_A_GAIN: modulation_gain_frequency <= clamp_s(reg_wdata);
        `TFS_A_ALTGAIN: alt_modulation_gain_frequency <= clamp_s(reg_wdata);
        // RULE13: selector range kept
        `TFS_A_INSEL: modulation_input_selector <=
          (reg_wdata > {13'h0000, `TFS_INSEL_MAX}) ? `TFS_INSEL_MAX : reg_wdata[2:0];
        // RULE17: offset rate limit
        `TFS_A_OFFSET: modulation_offset_rate <=
          (reg_wdata > {8'h00, `TFS_OFFSET_MAX}) ? `TFS_OFFSET_MAX : reg_wdata[7:0];
        `TFS_A_SRCSEL: first_speed_source_select <= reg_wdata[7:0];
        `TFS_A_LOOPMODE: control_loop_mode_select <= reg_wdata[7:0];
        `TFS_A_BIAS: bias_frequency_setting <= clamp_u(reg_wdata, `TFS_FREQ_MAX);
        `TFS_A_JOGFREQ: jog_freq <= clamp_u(reg_wdata, `TFS_FREQ_MAX);
        `TFS_A_GAINSEL: gain_alt_sel <= reg_wdata[0];
        default: begin
        end
      endcase
    end
  end

  // Terminal function table, one entry per input terminal
  genvar gi;
  wire [TERMS-1:0] term_is_hold;
  generate
    for (gi = 0; gi < TERMS; gi = gi + 1) begin : g_term
      localparam integer TIDX = gi;
      always @(posedge ref_clk) begin
        if (rst)
          term_func[gi] <= `TFS_R_BYTE;
        else if (reg_wr && reg_addr == `TFS_A_TERM0 + TIDX[7:0])
          term_func[gi] <= reg_wdata[7:0];
      end
      assign term_is_hold[gi] = (term_func[gi] == `TFS_HOLD_FUNC);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before anything reads a pin

  reg [6:0] pin_meta;
  reg [6:0] pin_sync;
  reg restart_prev;
  always @(posedge ref_clk) begin
    if (rst) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
      restart_prev <= 1'b0;
    end else begin
      pin_meta <= {run_cmd, jog_cmd, restart_req, ramp_select_input_a,
                   ramp_select_input_b, speed_select_input_a, speed_select_input_b};
      pin_sync <= pin_meta;
      restart_prev <= pin_sync[4];
    end
  end

  wire run_s = pin_sync[6];
  wire jog_s = pin_sync[5];
  wire restart_ev = pin_sync[4] & ~restart_prev;
  wire ramp_sel_s = pin_sync[3] | pin_sync[2];
  wire speed_sel_s = pin_sync[1] | pin_sync[0];

  // RULE1: traverse when selector is 2
  wire trav_mode = (operation_function_selector == `TFS_OP_TRAVERSE);
  wire hold_cfg = |term_is_hold;

  //////////////////////////////////////////////////////////////////////////
  // Analog modulation

  reg [12:0] norm_in;
  reg [12:0] cur_off;
  reg mod_src_on;
  // RULE13: decode selector to source
  always @* begin
    norm_in = 13'h0000;
    cur_off = 13'h0000;
    mod_src_on = 1'b1;
    case (modulation_input_selector)
      3'h1: norm_in = {voltage_mod_input_a, 1'b0};  // 0-5 V is half the ADC span
      3'h2: norm_in = {1'b0, voltage_mod_input_a};
      3'h3: norm_in = {voltage_mod_input_b, 1'b0};
      3'h4: norm_in = {1'b0, voltage_mod_input_b};
      3'h5: begin
        // 4 mA sits at one fifth of scale; stretch the rest by five quarters
        cur_off = (current_mod_input > `TFS_CUR_ZERO) ?
          {1'b0, current_mod_input - `TFS_CUR_ZERO} : 13'h0000;
        norm_in = cur_off + {2'b00, cur_off[12:2]};
      end
      default: mod_src_on = 1'b0;
    endcase
    if (norm_in > {1'b0, `TFS_ADC_FULL})
      norm_in = {1'b0, `TFS_ADC_FULL};
  end

  // RULE19: zero point at offset, span equal to gain
  // RULE22: linear in the digitized input
  wire [19:0] in_x100 = {7'h00, norm_in} * `TFS_PCT_SCALE;
  wire [19:0] off_x4096 = {modulation_offset_rate, 12'h000};
  wire signed [20:0] mod_diff = $signed({1'b0, in_x100}) - $signed({1'b0, off_x4096});
  // RULE16: signed gain gives falling slope
  wire signed [15:0] gain_sel = gain_alt_sel ? alt_modulation_gain_frequency :
                                modulation_gain_frequency;
  wire signed [36:0] mod_prod = gain_sel * mod_diff;
  // Divide by 409600 via reciprocal multiply; costs under 0.1 Hz of error
  wire signed [53:0] mod_wide = mod_prod * $signed({1'b0, `TFS_MOD_RECIP});
  // RULE12: only a nonzero selector modulates
  // RULE20: PID loop mode disables it
  // RULE21: bias register is not applied here
  wire mod_on = mod_src_on && (control_loop_mode_select != `TFS_PID_MODE);
  wire signed [17:0] mod_freq = mod_on ? mod_wide[49:32] : 18'h00000;

  // RULE15: working targets, stored setpoints untouched
  // RULE8: first setpoint straight from its register
  wire signed [18:0] work_a_raw = $signed({3'b000, first_speed_setpoint}) + mod_freq;
  wire signed [18:0] work_b_raw = $signed({3'b000, second_speed_setpoint}) + mod_freq;

  function [15:0] sat_freq;
    input signed [18:0] v;
    begin
      if (v < 0)
        sat_freq = 16'h0000;
      else if (v > $signed({3'b000, `TFS_FREQ_MAX}))
        sat_freq = `TFS_FREQ_MAX;
      else
        sat_freq = v[15:0];
    end
  endfunction

  wire [15:0] work_a = sat_freq(work_a_raw);
  wire [15:0] work_b = sat_freq(work_b_raw);
  // RULE3: first minus delta
  wire [15:0] over_a = sat_freq($signed({3'b000, work_a}) -
                                $signed({3'b000, traverse_step_delta}));
  // RULE4: second plus delta
  wire [15:0] over_b = sat_freq($signed({3'b000, work_b}) +
                                $signed({3'b000, traverse_step_delta}));

  //////////////////////////////////////////////////////////////////////////
  // Sequencer state machine

  wire at_target = (out_freq == target_freq);

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (run_s && trav_mode)
          next_state = S_START;
        else if (run_s || jog_s)
          next_state = S_PLAIN;  // RULE18: jog runs as ordinary
      end
      // RULE2: endless leg cycle
      // RULE5: reversal on touching endpoint
      S_START: if (at_target) next_state = S_LEG_B;
      S_LEG_B: if (at_target) next_state = S_OVER_B;
      S_OVER_B: if (at_target) next_state = S_LEG_A;
      S_LEG_A: if (at_target) next_state = S_OVER_A;
      S_OVER_A: if (at_target) next_state = S_LEG_B;
      S_STOP: begin
        if (run_s && trav_mode)
          next_state = S_START;
        else if (out_freq == 16'h0000)
          next_state = S_IDLE;
      end
      S_PLAIN: begin
        if (!run_s && !jog_s)
          next_state = S_STOP;
        else if (run_s && trav_mode && !jog_s)
          next_state = S_START;
      end
      default: next_state = S_IDLE;
    endcase
    // Stop and restart override any traverse leg
    if (state != S_IDLE && state != S_PLAIN && state != S_STOP && !run_s)
      next_state = S_STOP;
    // RULE11: restart heads for first setpoint
    else if (restart_ev && run_s && trav_mode && state != S_IDLE)
      next_state = S_START;
  end

  always @(posedge ref_clk) begin
    if (rst)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  assign traverse_active = trav_mode && (state != S_IDLE) && (state != S_PLAIN);

  // Target and ramp set per state
  reg [15:0] next_target;
  reg next_second;
  always @* begin
    next_target = 16'h0000;
    next_second = 1'b0;
    case (next_state)
      // RULE6: first times at start
      S_START: next_target = first_speed_setpoint;
      // RULE7: second times for legs
      S_LEG_B: begin
        next_target = work_b;
        next_second = 1'b1;
      end
      S_OVER_B: begin
        next_target = over_b;
        next_second = 1'b1;
      end
      S_LEG_A: begin
        next_target = work_a;
        next_second = 1'b1;
      end
      S_OVER_A: begin
        next_target = over_a;
        next_second = 1'b1;
      end
      S_PLAIN: begin
        // RULE10: speed pins only outside traverse
        if (jog_s)
          next_target = jog_freq;
        else if (speed_sel_s)
          next_target = second_speed_setpoint;
        else
          next_target = first_speed_setpoint;
        next_second = ramp_sel_s;
      end
      // RULE6: first times when stopping
      S_STOP: next_target = 16'h0000;
      default: next_target = 16'h0000;
    endcase
    // RULE9: ramp pins honoured only with hold
    if (trav_mode && hold_cfg && next_state != S_PLAIN && ramp_sel_s)
      next_second = 1'b1;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      target_freq <= 16'h0000;
      second_ramp_set <= 1'b0;
    end else begin
      target_freq <= next_target;
      second_ramp_set <= next_second;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Ramp generator: one 0.1 Hz step whenever the accumulator passes the
  // threshold; a time of T means 0 to 600 Hz in T tenths of a second

  wire rising = target_freq > out_freq;
  wire [15:0] ramp_time = rising ?
    (second_ramp_set ? second_accel_time : first_accel_time) :
    (second_ramp_set ? second_decel_time : first_decel_time);
  wire [55:0] thr_wide = {24'h000000, ramp_time} * {16'h0000, RCYC};
  wire [39:0] ramp_thr = thr_wide[39:0];
  reg [39:0] ramp_acc;
  wire [39:0] acc_next = ramp_acc + {24'h000000, `TFS_FREQ_MAX};
  wire ramp_step = (acc_next >= ramp_thr);

  always @(posedge ref_clk) begin
    if (rst) begin
      ramp_acc <= 40'h0000000000;
      out_freq <= 16'h0000;
    end else if (at_target) begin
      ramp_acc <= 40'h0000000000;  // Fresh start for every leg begun at a reached target
    end else if (ramp_step) begin
      ramp_acc <= acc_next - ramp_thr;
      out_freq <= rising ? out_freq + 16'h0001 : out_freq - 16'h0001;
    end else begin
      ramp_acc <= acc_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read port: data one cycle after the read strobe, else zero

  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `TFS_A_OPSEL: reg_rdata <= {13'h0000, operation_function_selector};
        `TFS_A_FIRST: reg_rdata <= first_speed_setpoint;
        `TFS_A_SECOND: reg_rdata <= second_speed_setpoint;
        `TFS_A_DELTA: reg_rdata <= traverse_step_delta;
        `TFS_A_ACC1: reg_rdata <= first_accel_time;
        `TFS_A_ACC2: reg_rdata <= second_accel_time;
        `TFS_A_DEC1: reg_rdata <= first_decel_time;
        `TFS_A_DEC2: reg_rdata <= second_decel_time;
        `TFS_A_GAIN: reg_rdata <= modulation_gain_frequency;
        `TFS_A_ALTGAIN: reg_rdata <= alt_modulation_gain_frequency;
        `TFS_A_INSEL: reg_rdata <= {13'h0000, modulation_input_selector};
        `TFS_A_OFFSET: reg_rdata <= {8'h00, modulation_offset_rate};
        `TFS_A_SRCSEL: reg_rdata <= {8'h00, first_speed_source_select};
        `TFS_A_LOOPMODE: reg_rdata <= {8'h00, control_loop_mode_select};
        `TFS_A_BIAS: reg_rdata <= bias_frequency_setting;
        `TFS_A_JOGFREQ: reg_rdata <= jog_freq;
        `TFS_A_GAINSEL: reg_rdata <= {15'h0000, gain_alt_sel};
        `TFS_A_STATUS: reg_rdata <= {10'h000, mod_on, second_ramp_set,
                                     traverse_active, state};
        `TFS_A_OUTFREQ: reg_rdata <= out_freq;
        `TFS_A_WORKA: reg_rdata <= work_a;
        `TFS_A_WORKB: reg_rdata <= work_b;
        `TFS_A_MOD: reg_rdata <= mod_freq[15:0];
        default: begin
          if (reg_addr >= `TFS_A_TERM0 && reg_addr < `TFS_A_TERM0 + TERMS)
            reg_rdata <= {8'h00, term_func[reg_addr[2:0]]};
          else
            reg_rdata <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// *** dv/tfs_seq_chk.sv ***
// Checker for the traverse sequencer outputs, bound to the design.
// Assumes it sees only the top module's ports, one clock domain.
`timescale 1ns/10ps
module tfs_seq_chk (
  input wire ref_clk,
  input wire rst,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [15:0] out_freq,
  input wire [15:0] target_freq,
  input wire second_ramp_set,
  input wire traverse_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Rest after reset, read data one cycle only
  reset_rest_a: assert property ($fell(rst) |-> out_freq == 16'h0000 && target_freq == 16'h0000)
    else $error("outputs not at rest after reset");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  // Start and stop legs keep the first time set
  start_set_a: assert property ($rose(traverse_active) |-> !second_ramp_set [*2])
    else $error("start leg on second time set");
  stop_set_a: assert property (traverse_active && target_freq == 16'h0000 |-> !second_ramp_set)
    else $error("stop leg on second time set");
  // A reached endpoint is left at once
  no_dwell_a: assert property (traverse_active && out_freq == target_freq &&
    target_freq != 16'h0000 |=> target_freq != $past(target_freq))
    else $error("target held after reach");
  hold_reached_a: assert property ($past(out_freq) == $past(target_freq) |-> $stable(out_freq))
    else $error("output moved past reached target");
  // Ramp moves one step at most, toward the target
  step_one_a: assert property (out_freq == $past(out_freq) ||
    out_freq == $past(out_freq) + 16'h0001 || out_freq == $past(out_freq) - 16'h0001)
    else $error("output jumped");
  ramp_up_a: assert property ($past(out_freq) < $past(target_freq) |-> out_freq >= $past(out_freq))
    else $error("output fell below target");
  ramp_down_a: assert property ($past(out_freq) > $past(target_freq) |-> out_freq <= $past(out_freq))
    else $error("output rose above target");
  target_cap_a: assert property (target_freq <= 16'h1770)
    else $error("target beyond limit");
endmodule

bind tfs_sequencer tfs_seq_chk i_chk (.ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .out_freq(out_freq), .target_freq(target_freq),
  .second_ramp_set(second_ramp_set), .traverse_active(traverse_active));

// *** dv/tfs_analog_src.sv ***
// Analog command sources feeding the modulation inputs.
// Assumes one clock shared with the sequencer; the bench sets the level.
`timescale 1ns/10ps
module tfs_analog_src (
  input wire ref_clk,
  input wire [2:0] src_sel,
  input wire [11:0] level,
  output logic [11:0] volt_a,
  output logic [11:0] volt_b,
  output logic [11:0] cur_in
);
  logic [11:0] churn = 12'h000;
  ////////////////////////////////////////
  // Idle sources wander, so a wrong pick shows up
  always @(posedge ref_clk) begin
    churn <= churn + 12'h2c5;
  end
  assign volt_a = (src_sel == 3'h1 || src_sel == 3'h2) ? level : churn;
  assign volt_b = (src_sel == 3'h3 || src_sel == 3'h4) ? level : ~churn;
  assign cur_in = (src_sel == 3'h5) ? level : churn ^ 12'h5a5;
endmodule

// *** dv/traverse_frequency_sequencer_tb.sv ***
// Self-checking bench for the traverse sequencer.
// Assumes the checker is bound in and the analog model feeds the inputs.
`timescale 1ns/10ps
`include "tfs_consts.vh"
module traverse_frequency_sequencer_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run_cmd = 1'b0;
  logic restart_req = 1'b0;
  logic jog_cmd = 1'b0;
  logic churn_on = 1'b1;
  logic [3:0] pins = 4'h0;
  logic [2:0] src_sel = 3'h0;
  logic [11:0] level = 12'h000;
  wire [15:0] reg_rdata, out_freq, target_freq;
  wire second_ramp_set, traverse_active;
  wire [11:0] volt_a, volt_b, cur_in;
  int fail_count = 0;
  int checked = 0;
  logic [15:0] rd_q[$];
  logic [16:0] tg_q[$];
  logic rd_d1 = 1'b0;
  logic [15:0] prev_tgt = 16'h0000;
  logic [16:0] seq[7] = '{17'h00064, 17'h10078, 17'h10082, 17'h10064, 17'h1005a, 17'h10078,
    17'h10082};
  int sel_t[5] = '{1, 2, 3, 4, 5};
  int gain_t[5] = '{500, 500, -300, -300, 600};
  int off_t[5] = '{0, 50, 0, 25, 10};
  longint m;
  int x;
  ////////////////////////////////////////
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pins <= churn_on ? 4'($urandom) : 4'h0;
  tfs_sequencer #(.RAMP_CYC(4)) i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .run_cmd(run_cmd), .jog_cmd(jog_cmd), .restart_req(restart_req),
    .ramp_select_input_a(pins[0]), .ramp_select_input_b(pins[1]),
    .speed_select_input_a(pins[2]), .speed_select_input_b(pins[3]),
    .voltage_mod_input_a(volt_a), .voltage_mod_input_b(volt_b), .current_mod_input(cur_in),
    .out_freq(out_freq), .target_freq(target_freq), .second_ramp_set(second_ramp_set),
    .traverse_active(traverse_active));
  tfs_analog_src i_src (.ref_clk(ref_clk), .src_sel(src_sel), .level(level),
    .volt_a(volt_a), .volt_b(volt_b), .cur_in(cur_in));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // Bounded wait until every noted result has been seen
  task automatic drain;
    int n;
    n = 0;
    while (rd_q.size() + tg_q.size() != 0 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("pending results", rd_q.size() + tg_q.size(), 0);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Results are matched against the oldest note as they appear
  always @(posedge ref_clk) begin
    if (rd_d1) begin
      check("read data", reg_rdata, rd_q.size() ? rd_q.pop_front() : 16'hxxxx);
    end
    if (!rst && target_freq !== prev_tgt) begin
      check("set and target", {second_ramp_set, target_freq},
        tg_q.size() ? tg_q.pop_front() : 17'hx);
    end
    rd_d1 <= reg_rd;
    prev_tgt <= target_freq;
  end
  // Cut a hang short; a full run needs under a thousand cycles
  initial begin
    #(25 * 20000);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h960516d5));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values, unmapped and read-only places, clamping
    for (int a = 0; a < 17; a++) rd(a[7:0], (a > 3 && a < 8) ? `TFS_R_TIME : 16'h0000);
    rd(8'h30, 16'h0000);
    wr(`TFS_A_OUTFREQ, 16'h0055);
    rd(`TFS_A_OUTFREQ, 16'h0000);
    wr(`TFS_A_FIRST, 16'hffff);
    rd(`TFS_A_FIRST, `TFS_FREQ_MAX);
    wr(`TFS_A_OFFSET, 16'h0064);
    rd(`TFS_A_OFFSET, 16'h0032);
    wr(`TFS_A_INSEL, 16'h0007);
    rd(`TFS_A_INSEL, 16'h0005);
    wr(`TFS_A_INSEL, 16'h0000);
    wr(`TFS_A_OPSEL, {13'h0000, `TFS_OP_TRAVERSE});
    wr(`TFS_A_FIRST, 16'h0064);
    wr(`TFS_A_SECOND, 16'h0078);
    wr(`TFS_A_DELTA, 16'h000a);
    for (int a = 4; a < 8; a++) wr(a[7:0], 16'h0000);
    // jog before traverse; pins held low so the set bit is known
    wr(`TFS_A_JOGFREQ, 16'h0032);
    tg_q.push_back(17'h00032);
    tg_q.push_back(17'h00000);
    churn_on <= 1'b0;
    repeat (4) @(posedge ref_clk);
    jog_cmd <= 1'b1;
    repeat (60) @(posedge ref_clk);
    jog_cmd <= 1'b0;
    drain;
    repeat (60) @(posedge ref_clk);
    churn_on <= 1'b1;
    foreach (seq[i]) tg_q.push_back(seq[i]);
    @(posedge ref_clk);
    run_cmd <= 1'b1;
    drain;
    check("traverse active", traverse_active, 1'b1);
    tg_q.push_back(17'h00064);
    for (int i = 1; i < 4; i++) tg_q.push_back(seq[i]);
    @(posedge ref_clk);
    restart_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    restart_req <= 1'b0;
    drain;
    tg_q.push_back(17'h00000);
    @(posedge ref_clk);
    run_cmd <= 1'b0;
    drain;
    repeat (150) @(posedge ref_clk);
    // Modulation per source code, gain sign and offset; bias must not matter
    wr(`TFS_A_OPSEL, 16'h0000);
    wr(`TFS_A_FIRST, 16'h03e8);
    wr(`TFS_A_BIAS, 16'h0123);
    for (int r = 0; r < 5; r++) begin
      x = sel_t[r] == 5 ? $urandom_range(4095, 819) : $urandom_range(sel_t[r] % 2 ? 2047 : 4095, 0);
      @(posedge ref_clk);
      src_sel <= sel_t[r][2:0];
      level <= x[11:0];
      wr(`TFS_A_GAINSEL, {15'h0000, r == 3});
      wr(r == 3 ? `TFS_A_ALTGAIN : `TFS_A_GAIN, gain_t[r][15:0]);
      wr(`TFS_A_OFFSET, off_t[r][15:0]);
      wr(`TFS_A_INSEL, sel_t[r][15:0]);
      m = sel_t[r] == 5 ? (x - 819) * 5 / 4 : (sel_t[r] % 2 ? x * 2 : x);
      // Divide by 409600 as a scaled reciprocal; the result floors, not truncates
      m = (gain_t[r] * (m * 100 - off_t[r] * 4096) * $signed({1'b0, `TFS_MOD_RECIP})) >>> 32;
      repeat (8) @(posedge ref_clk);
      rd(`TFS_A_MOD, m[15:0]);
      m = m + 1000;
      rd(`TFS_A_WORKA, m[15:0]);
    end
    rd(`TFS_A_FIRST, 16'h03e8);
    wr(`TFS_A_LOOPMODE, {8'h00, `TFS_PID_MODE});
    repeat (8) @(posedge ref_clk);
    rd(`TFS_A_MOD, 16'h0000);
    drain;
    tally_and_finish;
  end
endmodule
